// ===== rtl/irbc_top.sv
// Two-wire bus byte engine with double-buffered receive, guarded start and AXI4-Lite registers
`timescale 1ns/1ps
// ************************************************************
// How it works
// - Receive shift register plus separate receive buffer
// - Byte moved to buffer, then acknowledged, continue
// - Seventh data bit is the only hazard point
// - Buffer reads outside that bit never disturb
// - Abandoned slave reception answered with not-acknowledge
// - Receive flag drives a DMA request
// - Multi-master start waits idle for bus release
// - Start request reads one until start issued
// ************************************************************
module irbc_top
   import irbc_pkg::*;
#(
   parameter logic [15:0] DIV_RST = CLKDIV_RST
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic irq,
   output logic dma_rx_req
);
   // ************************************************************
   // Declarations
   // ************************************************************
   logic aw_got_q, w_got_q, bvalid_q, awready_q, wready_q, arready_q, rvalid_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q, wmask, merged;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic wr_en, rd_en, rd_rx, wr_tx, wr_ctrl, start_set, stop_set;
   logic en_q, mstr_q, mm_q, tr_q;
   logic [ADR_W-1:0] own_q, tgt_q;
   logic [15:0] clkdiv_q, div_q;
   logic [IRQ_W-1:0] istat_q, imask_q, ev_q, ev_all;
   logic irq_q, txf_q, txf_now, busy_q, clk_low_q, zero_q;
   logic scl_s, sda_s, scl_p_q, sda_p_q;
   logic scl_rise, scl_fall, start_det, stop_det, tick, drive_pt, addr_ok;
   irbc_state_t state_q;
   logic [3:0] bit_q;
   logic [7:0] shift_q, rxbuf_q, transmit_buffer_reg_q;
   logic sda_low_q, scl_low_q, master_q, txd_q, first_q, abort_q, pend_q, end_q;
   logic rx_full_q, tx_full_q, stt_q, stp_q, stop_ph_q;

   function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a);
      logic [31:0] w;
      w = 32'h0;
      unique case (a)
         OFS_CTRL: begin
            w[CTRL_EN] = en_q;
            w[CTRL_MSTR] = mstr_q;
            w[CTRL_MM] = mm_q;
            w[CTRL_TR] = tr_q;
            w[CTRL_STT] = stt_q;
            w[CTRL_STP] = stp_q;
            w[CTRL_OWN_LSB +: ADR_W] = own_q;
            w[CTRL_TGT_LSB +: ADR_W] = tgt_q;
         end
         OFS_STAT: begin
            w[STAT_BUSY] = busy_q;
            w[STAT_SCLLOW] = clk_low_q;
            w[STAT_RXF] = rx_full_q;
            w[STAT_TXF] = txf_q;
            w[STAT_MACT] = master_q;
         end
         OFS_RXBUF: w[7:0] = rxbuf_q;
         OFS_CLKDIV: w[15:0] = clkdiv_q;
         OFS_ISTAT: w[IRQ_W-1:0] = istat_q;
         OFS_IMASK: w[IRQ_W-1:0] = imask_q;
         default: w = 32'h0;
      endcase
      return w;
   endfunction

   // ************************************************************
   // Pin synchronisers and bus condition detection
   // ************************************************************
   irbc_sync #(.RST_VAL(1'b1)) u_scl_sync (.aclk(aclk), .aresetn(aresetn), .ce(ce), .din(scl_i), .dout(scl_s));
   irbc_sync #(.RST_VAL(1'b1)) u_sda_sync (.aclk(aclk), .aresetn(aresetn), .ce(ce), .din(sda_i), .dout(sda_s));

   assign scl_rise = scl_s && !scl_p_q;
   assign scl_fall = !scl_s && scl_p_q;
   assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
   assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;
   assign tick = (div_q == clkdiv_q);
   assign drive_pt = (state_q == st_xfer) && (scl_fall || (pend_q && !scl_s));
   assign addr_ok = (shift_q[7:1] == own_q) && !shift_q[0];
   assign txf_now = master_q && (state_q == st_xfer) && tr_q && !tx_full_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         busy_q <= 1'b0;
         clk_low_q <= 1'b0;
      end else if (ce) begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
         if (start_det) begin
            busy_q <= 1'b1;
         end else if (stop_det) begin
            busy_q <= 1'b0;
         end
         clk_low_q <= busy_q && !scl_s;
      end
   end

   // ************************************************************
   // AXI4-Lite slave
   // ************************************************************
   assign wr_en = aw_got_q && w_got_q && !bvalid_q;
   assign rd_en = arvalid && arready_q;
   assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   // The function reads register state, so a process keeps the merge current
   always_comb begin
      merged = (reg_word(awaddr_q) & ~wmask) | (wdata_q & wmask);
   end
   assign wr_ctrl = wr_en && (awaddr_q == OFS_CTRL);
   assign wr_tx = wr_en && (awaddr_q == OFS_TRANSMIT_BUFFER_REG) && wstrb_q[0];
   assign start_set = wr_ctrl && merged[CTRL_STT];
   assign stop_set = wr_ctrl && merged[CTRL_STP];
   assign rd_rx = rd_en && (araddr == OFS_RXBUF);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (ce) begin
         if (awvalid && awready_q) begin
            aw_got_q <= 1'b1;
            awaddr_q <= awaddr;
            awready_q <= 1'b0;
         end
         if (wvalid && wready_q) begin
            w_got_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
            wready_q <= 1'b0;
         end
         if (wr_en) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (awaddr_q[1:0] == 2'h0 && awaddr_q <= OFS_IMASK) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // Reads of the receive buffer only clear the flag, never touch the engine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= RESP_OKAY;
      end else if (ce) begin
         if (rd_en) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= reg_word(araddr);
            rresp_q <= (araddr[1:0] == 2'h0 && araddr <= OFS_IMASK) ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q <= 1'b0;
         mstr_q <= 1'b0;
         mm_q <= 1'b0;
         tr_q <= 1'b0;
         own_q <= OWN_RST;
         tgt_q <= TGT_RST;
         clkdiv_q <= DIV_RST;
         imask_q <= IMASK_RST;
      end else if (ce && wr_en) begin
         if (awaddr_q == OFS_CTRL) begin
            en_q <= merged[CTRL_EN];
            mstr_q <= merged[CTRL_MSTR];
            mm_q <= merged[CTRL_MM];
            tr_q <= merged[CTRL_TR];
            own_q <= merged[CTRL_OWN_LSB +: ADR_W];
            tgt_q <= merged[CTRL_TGT_LSB +: ADR_W];
         end
         if (awaddr_q == OFS_CLKDIV) begin
            clkdiv_q <= merged[15:0];
         end
         if (awaddr_q == OFS_IMASK) begin
            imask_q <= merged[IRQ_W-1:0];
         end
      end
   end

   // ************************************************************
   // Interrupts: sticky status, write one to clear, set wins
   // ************************************************************
   assign ev_all = ev_q | (IRQ_W'(txf_now && !txf_q) << IRQ_TX);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         istat_q <= '0;
         txf_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (ce) begin
         txf_q <= txf_now;
         if (wr_en && awaddr_q == OFS_ISTAT) begin
            istat_q <= (istat_q & ~(wdata_q[IRQ_W-1:0] & wmask[IRQ_W-1:0])) | ev_all;
         end else begin
            istat_q <= istat_q | ev_all;
         end
         irq_q <= |(istat_q & imask_q);
      end
   end

   // ************************************************************
   // Bit clock divider, held at zero while another device stretches the clock in st_xfer
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= 16'h0;
      end else if (ce) begin
         if (!master_q || tick || (state_q == st_xfer && !scl_low_q && !scl_s)) begin
            div_q <= 16'h0;
         end else begin
            div_q <= div_q + 16'h1;
         end
      end
   end

   // ************************************************************
   // Byte engine
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= st_idle;
         bit_q <= 4'h0;
         shift_q <= 8'h0;
         rxbuf_q <= 8'h0;
         transmit_buffer_reg_q <= 8'h0;
         {sda_low_q, scl_low_q, master_q, txd_q, first_q, abort_q, pend_q, end_q} <= 8'h0;
         {rx_full_q, tx_full_q, stt_q, stp_q, stop_ph_q} <= 5'h0;
         ev_q <= '0;
      end else if (ce) begin
         ev_q <= '0;
         if (rd_rx) begin
            rx_full_q <= 1'b0;
         end
         unique case (state_q)
            st_idle: begin
               // A pending start sits here untouched while the bus is occupied
               if (en_q && mstr_q && stt_q && !busy_q) begin
                  sda_low_q <= 1'b1;
                  master_q <= 1'b1;
                  state_q <= st_start;
               end else if (en_q && start_det) begin
                  {master_q, txd_q, abort_q, pend_q, end_q} <= 5'h0;
                  first_q <= 1'b1;
                  bit_q <= 4'h0;
                  state_q <= st_xfer;
               end
            end
            st_start: begin
               if (tick) begin
                  scl_low_q <= 1'b1;
                  stt_q <= 1'b0;
                  ev_q[IRQ_STT] <= 1'b1;
                  shift_q <= {tgt_q, !tr_q};
                  {txd_q, first_q} <= 2'h3;
                  {abort_q, pend_q, end_q} <= 3'h0;
                  bit_q <= 4'h0;
                  state_q <= st_xfer;
               end
            end
            st_xfer: begin
               if (tick && master_q && !pend_q) begin
                  if (scl_low_q) begin
                     scl_low_q <= 1'b0;
                  end else if (scl_s) begin
                     scl_low_q <= 1'b1;
                  end
               end
               if (drive_pt) begin
                  pend_q <= 1'b0;
                  if (bit_q == 4'd8) begin
                     if (txd_q) begin
                        sda_low_q <= 1'b0;
                     end else if (first_q) begin
                        sda_low_q <= addr_ok;
                        if (!addr_ok) begin
                           state_q <= st_idle;
                        end
                     end else if (abort_q) begin
                        sda_low_q <= 1'b0;
                        ev_q[IRQ_ABT] <= 1'b1;
                     end else if (rx_full_q) begin
                        pend_q <= 1'b1; // Master holds the clock low until read
                     end else begin
                        rxbuf_q <= shift_q;
                        rx_full_q <= 1'b1;
                        ev_q[IRQ_RX] <= 1'b1;
                        sda_low_q <= !(master_q && stp_q);
                        end_q <= master_q && stp_q;
                     end
                  end else if (bit_q == 4'd0 && (end_q || (txd_q && !first_q && !tx_full_q && stp_q))) begin
                     sda_low_q <= 1'b1;
                     scl_low_q <= 1'b1;
                     stop_ph_q <= 1'b0;
                     state_q <= st_stop;
                  end else if (bit_q == 4'd0 && txd_q && !first_q) begin
                     if (tx_full_q) begin
                        shift_q <= transmit_buffer_reg_q;
                        tx_full_q <= 1'b0;
                        sda_low_q <= !transmit_buffer_reg_q[7];
                     end else begin
                        pend_q <= 1'b1;
                     end
                  end else begin
                     sda_low_q <= txd_q && !shift_q[7];
                  end
               end
               if (scl_rise) begin
                  if (bit_q != 4'd8) begin
                     shift_q <= {shift_q[6:0], sda_s};
                     bit_q <= bit_q + 4'd1;
                     // Unread buffer while the seventh bit arrives: give up this byte
                     if (bit_q == 4'd6 && !master_q && !txd_q && !first_q && rx_full_q) begin
                        abort_q <= 1'b1;
                     end
                     if (master_q && mm_q && txd_q && !sda_low_q && !sda_s) begin
                        {master_q, sda_low_q, scl_low_q} <= 3'h0;
                        ev_q[IRQ_ARB] <= 1'b1;
                        state_q <= st_idle;
                     end
                  end else begin
                     bit_q <= 4'h0;
                     first_q <= 1'b0;
                     if (master_q && txd_q && sda_s) begin
                        end_q <= 1'b1;
                        ev_q[IRQ_NACK] <= 1'b1;
                     end
                     if (master_q && first_q && !tr_q) begin
                        txd_q <= 1'b0;
                     end
                     if (!master_q && abort_q) begin
                        state_q <= st_idle;
                     end
                  end
               end
               if (!master_q && start_det) begin
                  {txd_q, abort_q, sda_low_q} <= 3'h0;
                  first_q <= 1'b1;
                  bit_q <= 4'h0;
               end else if (!master_q && stop_det) begin
                  sda_low_q <= 1'b0;
                  state_q <= st_idle;
               end
            end
            st_stop: begin
               if (tick && !stop_ph_q) begin
                  scl_low_q <= 1'b0;
                  stop_ph_q <= 1'b1;
               end else if (tick && scl_s) begin
                  {sda_low_q, stp_q, master_q, end_q} <= 4'h0;
                  state_q <= st_idle;
               end
            end
         endcase
         if (!en_q) begin
            {sda_low_q, scl_low_q, master_q, stt_q, stp_q} <= 5'h0;
            state_q <= st_idle;
         end
         // Data written while the start is still pending is dropped
         if (wr_tx && !stt_q) begin
            transmit_buffer_reg_q <= wdata_q[7:0];
            tx_full_q <= 1'b1;
         end
         if (start_set) begin
            stt_q <= 1'b1;
         end
         if (stop_set) begin
            stp_q <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         zero_q <= 1'b0;
      end else if (ce) begin
         zero_q <= 1'b0;
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign scl_o = zero_q;
   assign sda_o = zero_q;
   assign scl_oe = scl_low_q;
   assign sda_oe = sda_low_q;
   assign irq = irq_q;
   assign dma_rx_req = rx_full_q;
endmodule

// ===== rtl/irbc_pkg.sv
// Package: register map, field layout, events and timing of the two-wire buffer control block
package irbc_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_STAT = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_RXBUF = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_TRANSMIT_BUFFER_REG = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_CLKDIV = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_ISTAT = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_IMASK = 5'h18;

   // ************************************************************
   // Control word fields
   // ************************************************************
   localparam int CTRL_EN = 0;
   localparam int CTRL_MSTR = 1;
   localparam int CTRL_MM = 2;
   localparam int CTRL_TR = 3;
   localparam int CTRL_STT = 4;
   localparam int CTRL_STP = 5;
   localparam int CTRL_OWN_LSB = 8;
   localparam int CTRL_TGT_LSB = 16;
   localparam int ADR_W = 7;
   localparam logic [ADR_W-1:0] OWN_RST = 7'h2a;
   localparam logic [ADR_W-1:0] TGT_RST = 7'h2b;

   // ************************************************************
   // Status word fields
   // ************************************************************
   localparam int STAT_BUSY = 0;
   localparam int STAT_SCLLOW = 1;
   localparam int STAT_RXF = 2;
   localparam int STAT_TXF = 3;
   localparam int STAT_MACT = 4;

   // ************************************************************
   // Interrupt status and mask bits
   // ************************************************************
   localparam int IRQ_W = 6;
   localparam int IRQ_RX = 0;
   localparam int IRQ_TX = 1;
   localparam int IRQ_NACK = 2;
   localparam int IRQ_STT = 3;
   localparam int IRQ_ARB = 4;
   localparam int IRQ_ABT = 5;
   localparam logic [IRQ_W-1:0] IMASK_RST = 6'h00;

   // ************************************************************
   // Timing: half-period count keeps repeated-start clocks below the limit
   // ************************************************************
   localparam int CLK_MHZ = 200;
   localparam int RPT_SCL_KHZ = 50;
   localparam logic [15:0] CLKDIV_RST = 16'(CLK_MHZ * 1000 / (2 * RPT_SCL_KHZ));

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {st_idle, st_start, st_xfer, st_stop} irbc_state_t;

endpackage

// ===== rtl/irbc_sync.sv
// Two-flop synchroniser for a bus pin
`timescale 1ns/1ps
module irbc_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic din,
   output logic dout
);
   logic meta_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= RST_VAL;
         dout <= RST_VAL;
      end else if (ce) begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

// ===== testbench/irbc_checker.sv
// Checker: port-level properties of the two-wire buffer control block
`timescale 1ns/1ps
module irbc_checker
   import irbc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic scl_o,
   input wire logic sda_o,
   input wire logic dma_rx_req
);
   // ****
   // Properties
   // ****
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wtake;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_rxread;
      arvalid && arready && araddr == OFS_RXBUF && dma_rx_req;
   endsequence
   a_write_resp: assert property (s_wtake |-> ##2 bvalid) else $error("write response late");
   a_wready_low: assert property (s_wtake |=> !awready && !wready) else $error("write ready stayed high");
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
   a_read_resp: assert property (arvalid && arready |=> rvalid) else $error("read data late");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
   a_unmapped_err: assert property (arvalid && arready && araddr == 5'h1c |=> rresp == RESP_SLVERR)
      else $error("unmapped read not refused");
   a_rxflag_clear: assert property (s_rxread |-> ##[1:3] !dma_rx_req)
      else $error("receive flag kept after read");
   a_open_drain: assert property (!scl_o && !sda_o) else $error("bus pin driven high");
endmodule
bind irbc_top irbc_checker chk_u (.*);

// ===== testbench/irbc_peer.sv
// Partner: a two-wire master that writes bytes and a slave that answers reads
`timescale 1ns/1ps
module irbc_peer (
   output logic scl_oe,
   output logic sda_oe,
   input wire logic scl,
   input wire logic sda
);
   // ****
   // Bus actions
   // ****
   initial begin
      scl_oe = 1'h0;
      sda_oe = 1'h0;
   end
   // Waits on the wire so slave stretching is honoured
   task automatic pulse(output logic s);
      #63;
      scl_oe = 1'h0;
      wait (scl);
      #31;
      s = sda;
      #31;
      scl_oe = 1'h1;
   endtask
   // Only ever on an idle bus, never a repeated start at this clock rate
   task automatic start_cond();
      sda_oe = 1'h1;
      #62;
      scl_oe = 1'h1;
   endtask
   task automatic stop_cond();
      sda_oe = 1'h1;
      #31;
      scl_oe = 1'h0;
      wait (scl);
      #62;
      sda_oe = 1'h0;
      #62;
   endtask
   task automatic put_byte(input logic [7:0] b, output logic nak);
      for (int i = 7; i >= 0; i--) begin
         sda_oe = !b[i];
         pulse(nak);
      end
      sda_oe = 1'h0;
      pulse(nak);
   endtask
   // Slave side: acks the address, then sends two bytes after falling clock edges
   task automatic answer(input logic [15:0] d);
      logic [15:0] s;
      s = d;
      repeat (9) @(negedge scl);
      #20;
      sda_oe = 1'h1;
      repeat (2) begin
         for (int i = 0; i < 8; i++) begin
            @(negedge scl);
            #20;
            sda_oe = !s[15];
            s = s << 1;
         end
         @(negedge scl);
         #20;
         sda_oe = 1'h0;
      end
   endtask
endmodule

// ===== testbench/tb.sv
// Testbench: register tasks and two-wire scenarios for the buffer control block
`timescale 1ns/1ps
module tb;
   import irbc_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
   logic [4:0] awaddr = 5'h0, araddr = 5'h0;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe, irq, dma_rx_req;
   logic p_scl, p_sda, ak;
   logic [1:0] bresp, rresp, rr, br;
   int fail_count = 0, check_count = 0;
   wire scl = !(scl_oe | p_scl);
   wire sda = !(sda_oe | p_sda);
   irbc_top #(.DIV_RST(16'h0018)) dut_u (.*, .scl_i(scl), .sda_i(sda));
   irbc_peer peer_u (.scl_oe(p_scl), .sda_oe(p_sda), .scl(scl), .sda(sda));
   always #2.5 aclk = !aclk;
   // ****
   // Tasks
   // ****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Handshake decided at the falling edge, released after the rising one
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic ta, tw, tk;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tk = bready & bvalid;
         br = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         if (tk) bready <= 1'h0;
      end while (!tk);
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tk;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(negedge aclk);
         ta = arvalid & arready;
         tk = rready & rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'h0;
         if (tk) rready <= 1'h0;
      end while (!tk);
   endtask
   task automatic rc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a, rv, rr);
      chk(rv & m, e);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   initial begin
      #200000;
      fail_count++;
      results();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rc(OFS_CTRL, 32'hffffffff, 32'h002b2a00);
      rc(OFS_CLKDIV, 32'hffff, 32'h18);
      rc(OFS_IMASK, 32'hff, 32'h0);
      rd(5'h1c, rv, rr);
      chk(32'(rr), 32'(RESP_SLVERR));
      wr(5'h1c, 32'h0);
      chk(32'(br), 32'(RESP_SLVERR));
      wr(OFS_CTRL, 32'h002b2a01);
      wr(OFS_IMASK, 32'h1);
      chk(32'(br), 32'(RESP_OKAY));
      peer_u.start_cond();
      peer_u.put_byte(8'h54, ak);
      chk(32'(ak), 32'h0);
      peer_u.put_byte(8'ha5, ak);
      chk(32'(ak), 32'h0);
      repeat (4) @(posedge aclk);
      chk(32'(dma_rx_req), 32'h1);
      chk(32'(irq), 32'h1);
      rc(OFS_STAT, 32'h6, 32'h6);
      // Three link clock periods of clock low before the read
      repeat (75) @(posedge aclk);
      rc(OFS_RXBUF, 32'hff, 32'ha5);
      chk(32'(dma_rx_req), 32'h0);
      wr(OFS_ISTAT, 32'h1);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h0);
      peer_u.put_byte(8'h3c, ak);
      chk(32'(ak), 32'h0);
      // Buffer left unread across the seventh bit of the next byte
      peer_u.put_byte(8'h77, ak);
      chk(32'(ak), 32'h1);
      peer_u.stop_cond();
      rc(OFS_RXBUF, 32'hff, 32'h3c);
      rc(OFS_ISTAT, 32'h20, 32'h20);
      wr(OFS_ISTAT, 32'h3f);
      peer_u.start_cond();
      // Busy seen set; the start is requested anyway to exercise the wait
      rc(OFS_STAT, 32'h1, 32'h1);
      wr(OFS_CTRL, 32'h002b2a1f);
      // Another master's traffic while the start waits for release
      peer_u.put_byte(8'h20, ak);
      chk(32'(ak), 32'h1);
      #2000;
      rc(OFS_CTRL, 32'h10, 32'h10);
      rc(OFS_STAT, 32'h9, 32'h1);
      rc(OFS_ISTAT, 32'h2, 32'h0);
      chk(32'(scl_oe), 32'h0);
      peer_u.stop_cond();
      #2000;
      rc(OFS_CTRL, 32'h10, 32'h0);
      wr(OFS_TRANSMIT_BUFFER_REG, 32'h5a);
      // Nobody answers the address, so the master ends with a stop
      #20000;
      rc(OFS_ISTAT, 32'hc, 32'hc);
      // Master receive: second byte stretched until the first is read
      fork
         peer_u.answer(16'hc35a);
         begin
            wr(OFS_CTRL, 32'h002b2a13);
            @(posedge aclk iff dma_rx_req);
            #4000;
            rc(OFS_STAT, 32'h6, 32'h6);
            repeat (75) @(posedge aclk);
            wr(OFS_CTRL, 32'h002b2a23);
            rc(OFS_RXBUF, 32'hff, 32'hc3);
         end
      join
      #2000;
      rc(OFS_RXBUF, 32'hff, 32'h5a);
      rc(OFS_STAT, 32'h11, 32'h0);
      results();
   end
endmodule
